// ---- tcoc_pkg.sv ----
package tcoc_pkg;

   // ==========================================================
   // Register map (byte addresses)
   // ==========================================================
   localparam logic [11:0] TCOC_OFS_CTRL = 12'h080;
   localparam logic [11:0] TCOC_OFS_STATUS = 12'h084;
   localparam logic [11:0] TCOC_OFS_BUF_A = 12'h088;
   localparam logic [11:0] TCOC_OFS_BUF_B = 12'h08C;
   localparam logic [11:0] TCOC_OFS_ACTIVE = 12'h090;

   // ==========================================================
   // Field layout of compare_wave_control_a
   // ==========================================================
   localparam int TCOC_MODE_A_POS = 6;
   localparam int TCOC_MODE_B_POS = 4;
   localparam int TCOC_WGM_LO_POS = 0;
   localparam logic [7:0] TCOC_CTRL_RESET = 8'h00;
   localparam logic [7:0] TCOC_CTRL_WMASK = 8'hF3;

   // ==========================================================
   // Status layout
   // ==========================================================
   localparam int TCOC_ST_FLAG_POS = 0;
   localparam int TCOC_ST_LEVEL_POS = 2;
   localparam int TCOC_ST_CONN_POS = 4;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [15:0] TCOC_MATCH_RESET = 16'h0000;
   localparam logic [15:0] TCOC_BOTTOM = 16'h0000;

   // ==========================================================
   // Compare output modes and waveform groups
   // ==========================================================
   typedef enum logic [1:0] {
      TCOC_COM_OFF = 2'b00,
      TCOC_COM_TOGGLE = 2'b01,
      TCOC_COM_CLEAR = 2'b10,
      TCOC_COM_SET = 2'b11
   } tcoc_com_type;

   typedef enum logic [1:0] {
      TCOC_GRP_NONPWM = 2'b00,
      TCOC_GRP_FAST = 2'b01,
      TCOC_GRP_DUAL_TOP = 2'b10,
      TCOC_GRP_DUAL_BOT = 2'b11
   } tcoc_grp_type;

   localparam logic [3:0] TCOC_WGM_PC_A = 4'hB;
   localparam logic [3:0] TCOC_WGM_PFC_A = 4'h9;
   localparam logic [3:0] TCOC_WGM_FAST_ICR = 4'hE;
   localparam logic [3:0] TCOC_WGM_FAST_A = 4'hF;

endpackage : tcoc_pkg

// ---- tcoc_compare_output.sv ----
`timescale 1ns/1ns
// Summary of operation
// - All logic runs on pclk; the timer tick is only a clock enable.
// - Phase and frequency correct PWM loads compare registers from buffers at BOTTOM.
// - A nonzero channel output mode hands the pin to the compare output, except a toggle (01) that the PWM mode does not allow.
// - The pin driver is enabled only when its direction bit selects output.
// - Output mode meaning depends on non-PWM, fast PWM or dual-slope mode.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM 01 toggles channel A only in modes 14, 15; else off.
// - Fast PWM 10 clears on match and sets at BOTTOM.
// - Fast PWM 11 sets on match and clears at BOTTOM.
// - Fast PWM 10 and 11 ignore a match at TOP but still act at BOTTOM.
// - Dual-slope 01 toggles channel A only in modes 9, 11; else off.
// - Dual-slope 10 clears on up-count match, sets on down-count match.
// - Dual-slope 11 sets on up-count match, clears on down-count match.
// - Control register at 0x80 resets to 0x00 with modes high, wave low.
// - Waveform mode joins two low control bits with two high bits outside.
// - Dual-slope compare at BOTTOM holds low, at TOP holds high, inverted swaps.
module tcoc_compare_output
   import tcoc_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int CNT_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_tick_enable,
   input wire logic [CNT_W-1:0] counter_value,
   input wire logic count_down,
   input wire logic [CNT_W-1:0] top_value,
   input wire logic [1:0] wave_mode_high,
   input wire logic port_dir_a,
   input wire logic port_dir_b,
   input wire logic port_data_a,
   input wire logic port_data_b,
   output logic chan_a_wave_out,
   output logic chan_a_wave_oe,
   output logic chan_b_wave_out,
   output logic chan_b_wave_oe,
   output logic [1:0] chan_match_flag
);

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [1:0] chan_a_output_mode;
      logic [1:0] chan_b_output_mode;
      logic [1:0] wave_mode_low;
      logic [1:0][CNT_W-1:0] match_buffer;
      logic [1:0][CNT_W-1:0] chan_match_value;
      logic [1:0] wave_level;
      logic [1:0] match_pending;
      logic [1:0] match_flag;
      logic [1:0] pin_out;
      logic [1:0] pin_oe;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
   } tcoc_state_type;

   tcoc_state_type s_q;
   tcoc_state_type s_d;

   // ==========================================================
   // Mode decode
   // ==========================================================
   logic [3:0] waveform_mode_select;
   tcoc_grp_type grp;
   logic at_bottom;
   logic at_top;
   logic tick;
   logic [1:0][1:0] com;
   logic [1:0] port_dir;
   logic [1:0] port_data;
   logic apb_access;
   logic apb_write;
   logic apb_read;

   assign waveform_mode_select = {wave_mode_high, s_q.wave_mode_low};
   assign at_bottom = (counter_value == CNT_W'(TCOC_BOTTOM));
   assign at_top = (counter_value == top_value);
   assign tick = clk_en & timer_tick_enable;
   assign com[1] = s_q.chan_a_output_mode;
   assign com[0] = s_q.chan_b_output_mode;
   assign port_dir = {port_dir_a, port_dir_b};
   assign port_data = {port_data_a, port_data_b};
   assign apb_access = psel & penable & s_q.ready;
   assign apb_write = apb_access & pwrite;
   assign apb_read = apb_access & ~pwrite;

   always_comb begin
      unique case (waveform_mode_select)
         4'h1, 4'h2, 4'h3, 4'hA, 4'hB: grp = TCOC_GRP_DUAL_TOP;
         4'h8, 4'h9: grp = TCOC_GRP_DUAL_BOT;
         4'h5, 4'h6, 4'h7, 4'hE, 4'hF: grp = TCOC_GRP_FAST;
         default: grp = TCOC_GRP_NONPWM;
      endcase
   end

   // ==========================================================
   // Output connection per channel
   // ==========================================================
   logic [1:0] connected;
   logic toggle_ok_fast;
   logic toggle_ok_dual;

   assign toggle_ok_fast = (waveform_mode_select == TCOC_WGM_FAST_ICR)
                           | (waveform_mode_select == TCOC_WGM_FAST_A);
   assign toggle_ok_dual = (waveform_mode_select == TCOC_WGM_PC_A)
                           | (waveform_mode_select == TCOC_WGM_PFC_A);

   always_comb begin
      for (int ch = 0; ch < 2; ch++) begin
         if (com[ch] == TCOC_COM_OFF) begin
            connected[ch] = 1'b0;
         end else if (com[ch] == TCOC_COM_TOGGLE && grp != TCOC_GRP_NONPWM) begin
            // Only channel A (index 1) may toggle in PWM modes
            if (grp == TCOC_GRP_FAST) begin
               connected[ch] = (ch == 1) && toggle_ok_fast;
            end else begin
               connected[ch] = (ch == 1) && toggle_ok_dual;
            end
         end else begin
            connected[ch] = 1'b1;
         end
      end
   end

   // ==========================================================
   // Register read mux
   // ==========================================================
   logic [31:0] rd_mux;
   logic addr_hit;

   always_comb begin
      rd_mux = 32'h0000_0000;
      addr_hit = 1'b1;
      unique case (paddr)
         ADDR_W'(TCOC_OFS_CTRL): begin
            rd_mux[TCOC_MODE_A_POS +: 2] = s_q.chan_a_output_mode;
            rd_mux[TCOC_MODE_B_POS +: 2] = s_q.chan_b_output_mode;
            rd_mux[TCOC_WGM_LO_POS +: 2] = s_q.wave_mode_low;
         end
         ADDR_W'(TCOC_OFS_STATUS): begin
            rd_mux[TCOC_ST_FLAG_POS +: 2] = s_q.match_flag;
            rd_mux[TCOC_ST_LEVEL_POS +: 2] = s_q.wave_level;
            rd_mux[TCOC_ST_CONN_POS +: 2] = connected;
         end
         ADDR_W'(TCOC_OFS_BUF_A): begin
            rd_mux[CNT_W-1:0] = s_q.match_buffer[1];
         end
         ADDR_W'(TCOC_OFS_BUF_B): begin
            rd_mux[CNT_W-1:0] = s_q.match_buffer[0];
         end
         ADDR_W'(TCOC_OFS_ACTIVE): begin
            rd_mux[15:0] = 16'(s_q.chan_match_value[1]);
            rd_mux[31:16] = 16'(s_q.chan_match_value[0]);
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Next state
   // ==========================================================
   logic [1:0] match_now;
   logic [1:0] flag_clear;
   logic [1:0] buf_write;
   logic load_cmp;

   always_comb begin
      s_d = s_q;
      match_now = 2'b00;
      flag_clear = 2'b00;
      buf_write = 2'b00;
      load_cmp = 1'b0;

      // APB slave: one wait state, answer in the access phase
      // Ready is a one-cycle pulse; a held access phase gets it again every second cycle and repeats the write
      s_d.ready = psel & penable & ~s_q.ready;
      s_d.slverr = psel & penable & ~s_q.ready & ~addr_hit;
      if (psel & penable & ~s_q.ready & ~pwrite) begin
         s_d.rdata = rd_mux;
      end

      if (apb_write) begin
         unique case (paddr)
            ADDR_W'(TCOC_OFS_CTRL): begin
               // Bits 3:2 are not stored
               s_d.chan_a_output_mode = pwdata[TCOC_MODE_A_POS +: 2];
               s_d.chan_b_output_mode = pwdata[TCOC_MODE_B_POS +: 2];
               s_d.wave_mode_low = pwdata[TCOC_WGM_LO_POS +: 2];
            end
            ADDR_W'(TCOC_OFS_STATUS): begin
               flag_clear = pwdata[TCOC_ST_FLAG_POS +: 2];
            end
            ADDR_W'(TCOC_OFS_BUF_A): begin
               buf_write[1] = 1'b1;
            end
            ADDR_W'(TCOC_OFS_BUF_B): begin
               buf_write[0] = 1'b1;
            end
            default: begin
            end
         endcase
      end

      for (int ch = 0; ch < 2; ch++) begin
         if (buf_write[ch]) begin
            s_d.match_buffer[ch] = pwdata[CNT_W-1:0];
         end
      end

      // Compare register update point depends on waveform group
      // Non-PWM modes copy the buffer on every cycle, so a write lands at once
      unique case (grp)
         TCOC_GRP_NONPWM: load_cmp = 1'b1;
         TCOC_GRP_DUAL_TOP: load_cmp = tick & at_top;
         TCOC_GRP_DUAL_BOT: load_cmp = tick & at_bottom;
         TCOC_GRP_FAST: load_cmp = tick & at_bottom;
      endcase

      for (int ch = 0; ch < 2; ch++) begin
         // The compare uses the active value, never the buffer
         match_now[ch] = (counter_value == s_q.chan_match_value[ch]);

         if (tick) begin
            // Flag follows the tick after the equal count
            s_d.match_pending[ch] = match_now[ch];
         end
         if (flag_clear[ch]) begin
            s_d.match_flag[ch] = 1'b0;
         end
         // Set after clear: a match beats a software clear in the same cycle
         if (tick & s_q.match_pending[ch]) begin
            s_d.match_flag[ch] = 1'b1;
         end

         if (tick && connected[ch]) begin
            unique case (grp)
               TCOC_GRP_NONPWM: begin
                  if (match_now[ch]) begin
                     unique case (com[ch])
                        TCOC_COM_TOGGLE: s_d.wave_level[ch] = ~s_q.wave_level[ch];
                        TCOC_COM_CLEAR: s_d.wave_level[ch] = 1'b0;
                        TCOC_COM_SET: s_d.wave_level[ch] = 1'b1;
                        default: s_d.wave_level[ch] = s_q.wave_level[ch];
                     endcase
                  end
               end
               TCOC_GRP_FAST: begin
                  if (com[ch] == TCOC_COM_TOGGLE) begin
                     if (match_now[ch]) begin
                        s_d.wave_level[ch] = ~s_q.wave_level[ch];
                     end
                  end else begin
                     if (at_bottom) begin
                        s_d.wave_level[ch] = (com[ch] == TCOC_COM_CLEAR);
                     end
                     // A compare at TOP would undo the BOTTOM action, so it is skipped
                     if (match_now[ch] && !(s_q.chan_match_value[ch] == top_value)) begin
                        s_d.wave_level[ch] = (com[ch] == TCOC_COM_SET);
                     end
                  end
               end
               default: begin
                  if (com[ch] == TCOC_COM_TOGGLE) begin
                     if (match_now[ch]) begin
                        s_d.wave_level[ch] = ~s_q.wave_level[ch];
                     end
                  end else if (s_q.chan_match_value[ch] == CNT_W'(TCOC_BOTTOM)) begin
                     s_d.wave_level[ch] = (com[ch] == TCOC_COM_SET);
                  end else if (s_q.chan_match_value[ch] == top_value) begin
                     s_d.wave_level[ch] = (com[ch] == TCOC_COM_CLEAR);
                  end else if (match_now[ch]) begin
                     // Non-inverting clears going up, sets going down
                     s_d.wave_level[ch] = (com[ch] == TCOC_COM_CLEAR)
                                          ? count_down : ~count_down;
                  end
               end
            endcase
         end

         if (load_cmp) begin
            s_d.chan_match_value[ch] = buf_write[ch] ? pwdata[CNT_W-1:0]
                                                     : s_d.match_buffer[ch];
         end

         // Pin value comes from the next level, so it carries no extra cycle of lag
         s_d.pin_out[ch] = connected[ch] ? s_d.wave_level[ch] : port_data[ch];
         s_d.pin_oe[ch] = port_dir[ch];
      end

      // A low enable holds every register, the bus answer included
      if (!clk_en) begin
         s_d = s_q;
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Flags, levels and bus outputs start low; fields get their reset values
         s_q <= '0;
         s_q.chan_a_output_mode <= TCOC_CTRL_RESET[TCOC_MODE_A_POS +: 2];
         s_q.chan_b_output_mode <= TCOC_CTRL_RESET[TCOC_MODE_B_POS +: 2];
         s_q.wave_mode_low <= TCOC_CTRL_RESET[TCOC_WGM_LO_POS +: 2];
         s_q.match_buffer <= {2{CNT_W'(TCOC_MATCH_RESET)}};
         s_q.chan_match_value <= {2{CNT_W'(TCOC_MATCH_RESET)}};
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign prdata = s_q.rdata;
   assign pready = s_q.ready;
   assign pslverr = s_q.slverr;
   assign chan_a_wave_out = s_q.pin_out[1];
   assign chan_a_wave_oe = s_q.pin_oe[1];
   assign chan_b_wave_out = s_q.pin_out[0];
   assign chan_b_wave_oe = s_q.pin_oe[0];
   assign chan_match_flag = s_q.match_flag;

endmodule : tcoc_compare_output

// ---- tcoc_compare_output_checker.sv ----
`timescale 1ns/1ns
module tcoc_compare_output_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_tick_enable,
   input wire logic port_dir_a,
   input wire logic port_dir_b,
   input wire logic chan_a_wave_out,
   input wire logic chan_a_wave_oe,
   input wire logic chan_b_wave_oe,
   input wire logic [1:0] chan_match_flag
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ==========================================================
   // Bus phases
   // ==========================================================
   sequence s_setup;
      psel && !penable && clk_en;
   endsequence
   sequence s_access;
      psel && penable && clk_en;
   endsequence
   // ==========================================================
   // Properties
   // ==========================================================
   AST_OE_A: assert property (clk_en |=> chan_a_wave_oe == $past(port_dir_a))
      else $error("oe a does not follow direction");
   AST_OE_B: assert property (clk_en |=> chan_b_wave_oe == $past(port_dir_b))
      else $error("oe b does not follow direction");
   AST_FLAG_A: assert property ($rose(chan_match_flag[1]) |-> $past(timer_tick_enable))
      else $error("flag a set without tick");
   AST_FLAG_B: assert property ($rose(chan_match_flag[0]) |-> $past(timer_tick_enable))
      else $error("flag b set without tick");
   AST_FREEZE: assert property (!clk_en |=> $stable(chan_a_wave_out) && $stable(chan_match_flag))
      else $error("state moved while enable low");
   AST_WAIT_STATE: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
      else $error("access phase length wrong");
   AST_READY_PULSE: assert property (pready && clk_en |=> !pready)
      else $error("ready longer than one cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
      else $error("error outside completion");
endmodule : tcoc_compare_output_checker

bind tcoc_compare_output tcoc_compare_output_checker i_tcoc_compare_output_checker (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .timer_tick_enable(timer_tick_enable),
   .port_dir_a(port_dir_a), .port_dir_b(port_dir_b), .chan_a_wave_out(chan_a_wave_out),
   .chan_a_wave_oe(chan_a_wave_oe), .chan_b_wave_oe(chan_b_wave_oe),
   .chan_match_flag(chan_match_flag));

// ---- tcoc_pin_model.sv ----
`timescale 1ns/1ns
module tcoc_pin_model (
   input wire logic drv,
   input wire logic oe,
   output logic pin
);
   logic last;
   initial last = 1'b0;
   // Undriven pin has no pull, so it shows the inverse of the last level
   always @(drv or oe) if (oe) last = drv;
   assign pin = oe ? drv : ~last;
endmodule : tcoc_pin_model

// ---- tcoc_compare_output_tb.sv ----
`timescale 1ns/1ns
module tcoc_compare_output_tb
   import tcoc_pkg::*;
;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic timer_tick_enable, count_down, port_dir_a, port_dir_b, port_data_a, port_data_b;
   logic [15:0] counter_value, top_value;
   logic [1:0] wave_mode_high, chan_match_flag;
   logic chan_a_wave_out, chan_a_wave_oe, chan_b_wave_out, chan_b_wave_oe, pin_a, v;
   logic [3:0] wl [3] = '{4'h5, TCOC_WGM_FAST_A, TCOC_WGM_PFC_A};
   int fails = 0;
   int n_compared = 0;
   tcoc_compare_output i_tcoc_compare_output (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_tick_enable(timer_tick_enable),
      .counter_value(counter_value), .count_down(count_down), .top_value(top_value),
      .wave_mode_high(wave_mode_high), .port_dir_a(port_dir_a), .port_dir_b(port_dir_b),
      .port_data_a(port_data_a), .port_data_b(port_data_b), .chan_a_wave_out(chan_a_wave_out),
      .chan_a_wave_oe(chan_a_wave_oe), .chan_b_wave_out(chan_b_wave_out),
      .chan_b_wave_oe(chan_b_wave_oe), .chan_match_flag(chan_match_flag));
   tcoc_pin_model i_tcoc_pin_model (.drv(chan_a_wave_out), .oe(chan_a_wave_oe), .pin(pin_a));
   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic tick(input logic [15:0] c, input logic d);
      counter_value <= c; count_down <= d; timer_tick_enable <= 1'b1;
      @(posedge pclk);
      timer_tick_enable <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : tick
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   // ==========================================================
   // Clock, watchdog, tests
   // ==========================================================
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      #800000;
      fails++;
      stop_test();
   end
   initial begin
      presetn = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      timer_tick_enable = 0; counter_value = 0; count_down = 0; top_value = 16'h0008;
      wave_mode_high = 0; port_dir_a = 0; port_dir_b = 0; port_data_a = 0; port_data_b = 1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, TCOC_OFS_CTRL, 32'h0);
      chk("ctrl_reset", 32'h0, r);
      chk("a_port", 32'h0, 32'(chan_a_wave_out));
      chk("a_oe_off", 32'h0, 32'(chan_a_wave_oe));
      port_dir_a <= 1'b1; port_dir_b <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("a_pin", 32'h0, 32'(pin_a));
      chk("b_oe_on", 32'h1, 32'(chan_b_wave_oe));
      apb(1'b1, TCOC_OFS_CTRL, 32'hFF);
      apb(1'b0, TCOC_OFS_CTRL, 32'h0);
      chk("ctrl_reserved", 32'hF3, r);
      apb(1'b0, 12'hFC, 32'h0);
      chk("unmapped_err", 32'h1, 32'(e));
      apb(1'b1, TCOC_OFS_CTRL, 32'hE0);
      apb(1'b1, TCOC_OFS_BUF_A, 32'h5);
      apb(1'b1, TCOC_OFS_BUF_B, 32'h5);
      tick(16'h5, 1'b0);
      chk("np_set_a", 32'h1, 32'(chan_a_wave_out));
      chk("np_clr_b", 32'h0, 32'(chan_b_wave_out));
      chk("flag_early", 32'h0, 32'(chan_match_flag));
      tick(16'h6, 1'b0);
      chk("flag_set", 32'h3, 32'(chan_match_flag));
      apb(1'b1, TCOC_OFS_STATUS, 32'h2);
      chk("flag_clear", 32'h1, 32'(chan_match_flag));
      apb(1'b0, TCOC_OFS_ACTIVE, 32'h0);
      chk("active", 32'h0005_0005, r);
      apb(1'b1, TCOC_OFS_CTRL, 32'h50);
      tick(16'h5, 1'b0);
      chk("np_tog_a", 32'h0, 32'(chan_a_wave_out));
      chk("np_tog_b", 32'h1, 32'(chan_b_wave_out));
      clk_en <= 1'b0; timer_tick_enable <= 1'b1;
      repeat (3) @(posedge pclk);
      clk_en <= 1'b1; timer_tick_enable <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("frozen_a", 32'h0, 32'(chan_a_wave_out));
      for (int m = 2; m < 4; m++) begin
         wave_mode_high <= 2'b01;
         apb(1'b1, TCOC_OFS_CTRL, 32'(m << 6 | 1));
         apb(1'b1, TCOC_OFS_BUF_A, 32'h3);
         tick(16'h0, 1'b0);
         chk("fast_bottom", 32'(m == 2), 32'(chan_a_wave_out));
         tick(16'h3, 1'b0);
         chk("fast_match", 32'(m == 3), 32'(chan_a_wave_out));
         top_value <= 16'h0003;
         tick(16'h0, 1'b0);
         tick(16'h3, 1'b0);
         chk("fast_top", 32'(m == 2), 32'(chan_a_wave_out));
         top_value <= 16'h0008;
      end
      for (int i = 0; i < 3; i++) begin
         wave_mode_high <= wl[i][3:2];
         apb(1'b1, TCOC_OFS_CTRL, {28'h5, 2'b00, wl[i][1:0]});
         apb(1'b1, TCOC_OFS_BUF_A, 32'h4);
         tick(16'h0, 1'b0);
         v = chan_a_wave_out;
         tick(16'h4, 1'b0);
         if (i > 0) chk("tog_a", 32'(!v), 32'(chan_a_wave_out));
         else chk("tog_off_a", 32'(port_data_a), 32'(chan_a_wave_out));
         chk("tog_off_b", 32'(port_data_b), 32'(chan_b_wave_out));
      end
      for (int m = 2; m < 4; m++) begin
         wave_mode_high <= 2'b10;
         apb(1'b1, TCOC_OFS_CTRL, 32'(m << 6 | 1));
         apb(1'b1, TCOC_OFS_BUF_A, 32'h4);
         tick(16'h0, 1'b0);
         tick(16'h4, 1'b0);
         chk("dual_up", 32'(m == 3), 32'(chan_a_wave_out));
         tick(16'h4, 1'b1);
         chk("dual_down", 32'(m == 2), 32'(chan_a_wave_out));
         apb(1'b1, TCOC_OFS_BUF_A, 32'h0);
         tick(16'h0, 1'b0);
         tick(16'h2, 1'b0);
         chk("dual_bottom", 32'(m == 3), 32'(chan_a_wave_out));
         apb(1'b1, TCOC_OFS_BUF_A, 32'h8);
         tick(16'h0, 1'b0);
         tick(16'h2, 1'b1);
         chk("dual_top", 32'(m == 2), 32'(chan_a_wave_out));
      end
      stop_test();
   end
endmodule : tcoc_compare_output_tb
